// *** logic/fdr_id_reads.v ***
// serial flash identification and discovery read interpreter
`timescale 1ns/1ps
`default_nettype none
`include "fdr_map.vh"

module fdr_id_reads #(
	parameter [7:0]  MFR_ID    = 8'h3c,                 // arbitrary value
	parameter [7:0]  DEV_ID    = 8'h17,                 // arbitrary value
	parameter [7:0]  MEM_TYPE  = 8'h40,                 // arbitrary value
	parameter [7:0]  CAPACITY  = 8'h18,                 // arbitrary value
	parameter [63:0] UNIQUE_ID = 64'h0123456789abcdef   // arbitrary value
) (
	input  wire       clk,        // block clock, 200 MHz
	input  wire       rst_n,      // asynchronous reset, active low
	input  wire       sclk,       // serial clock pin from host
	input  wire       csN,        // chip select pin, active low
	input  wire [3:0] ioIn,       // io pins as seen, bit 0 is serial_in_line
	output wire [3:0] ioOut,      // io pin drive values
	output wire [3:0] ioOe,       // io pin drive enables, high drives
	input  wire       powerDown,  // device is in power-down state
	output wire       busyRead    // a read instruction is in data phase
);

	// ---------------------------------------------------------------
	// reset release
	// ---------------------------------------------------------------
	reg rstMeta_q;
	reg rstSync_q;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta_q <= 1'b0;
			rstSync_q <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstSync_q <= rstMeta_q;
		end
	end

	wire rstN = rstSync_q;

	// ---------------------------------------------------------------
	// pin sampling and edge finding
	// ---------------------------------------------------------------
	// each pin costs four to five clocks of latency, so every serial
	// clock phase must last well over five block clocks
	wire [5:0] pinStable;

	fdr_pin_sync #(
		.WIDTH     (6),
		.RESET_VAL (6'h20)
	) uSync (
		.clk    (clk),
		.rstN   (rstN),
		.pinIn  ({csN, sclk, ioIn}),
		.stable (pinStable)
	);

	wire       csS   = pinStable[5];
	wire       sclkS = pinStable[4];
	wire [3:0] ioS   = pinStable[3:0];

	reg  sclkPrev_q;
	wire sclkRise = sclkS & ~sclkPrev_q;
	wire sclkFall = ~sclkS & sclkPrev_q;

	always @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			sclkPrev_q <= 1'b0;
		end else begin
			sclkPrev_q <= sclkS;
		end
	end

	// ---------------------------------------------------------------
	// instruction state
	// ---------------------------------------------------------------
	localparam [1:0] ST_CMD    = 2'b00;
	localparam [1:0] ST_ADDR   = 2'b01;
	localparam [1:0] ST_DATA   = 2'b10;
	localparam [1:0] ST_IGNORE = 2'b11;

	// pin drive enables: none, io1 only, all four lines
	localparam [3:0] OE_NONE   = 4'h0;
	localparam [3:0] OE_SINGLE = 4'h2;
	localparam [3:0] OE_QUAD   = 4'hf;

	reg [1:0]  state_q;
	reg [1:0]  state_d;
	reg [6:0]  cnt_q;
	reg [7:0]  opcode_q;
	reg [23:0] addr_q;
	reg [7:0]  byteSel_q;
	reg [2:0]  unitPos_q;
	reg [3:0]  ioOut_q;
	reg [3:0]  ioOe_q;
	reg        busyRead_q;

	wire [7:0] opcodeNext = {opcode_q[6:0], ioS[0]};
	wire       isQuad     = (opcode_q == `FDR_OP_QUAD_ID);

	// clocks that must pass before output, per instruction
	reg [6:0] dataStart;
	always @* begin
		case (opcode_q)
			`FDR_OP_QUAD_ID:     dataStart = `FDR_QUAD_ID_CLKS;
			`FDR_OP_UNIQUE_ID:   dataStart = `FDR_UNIQUE_ID_CLKS;
			default:             dataStart = `FDR_PARAM_CLKS;
		endcase
	end

	always @* begin
		state_d = state_q;
		case (state_q)
			ST_CMD: begin
				if (sclkRise && cnt_q == `FDR_OPCODE_CLKS - 7'h01) begin
					if (powerDown) begin
						state_d = ST_IGNORE;
					end else if (opcodeNext == `FDR_OP_JEDEC_ID) begin
						state_d = ST_DATA;
					end else if (opcodeNext == `FDR_OP_QUAD_ID ||
						opcodeNext == `FDR_OP_UNIQUE_ID ||
						opcodeNext == `FDR_OP_PARAM_TABLE) begin
						state_d = ST_ADDR;
					end else begin
						state_d = ST_IGNORE;
					end
				end
			end
			ST_ADDR: begin
				// address, mode and dummy clocks all count toward one start point
				if (sclkRise && cnt_q == dataStart - 7'h01) begin
					state_d = ST_DATA;
				end
			end
			ST_DATA: begin
				// stays until select rises, however long the host clocks
				state_d = ST_DATA;
			end
			ST_IGNORE: begin
				// refused opcode or power-down: silent until select rises
				state_d = ST_IGNORE;
			end
			default: begin
				state_d = ST_CMD;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// output byte selection
	// ---------------------------------------------------------------
	wire [7:0] tableData;

	fdr_param_table uTable (
		.byteAddr (byteSel_q),
		.byteData (tableData)
	);

	// unique number is a parameter: nothing can write it
	wire [5:0] uidBase = {3'h7 - byteSel_q[2:0], 3'h0};
	wire [7:0] uidByte = UNIQUE_ID[uidBase +: 8];

	reg [7:0] curByte;
	always @* begin
		case (opcode_q)
			`FDR_OP_JEDEC_ID: begin
				if (byteSel_q == 8'h00) begin
					curByte = MFR_ID;
				end else if (byteSel_q == 8'h01) begin
					curByte = MEM_TYPE;
				end else begin
					curByte = CAPACITY;
				end
			end
			`FDR_OP_UNIQUE_ID: curByte = uidByte;
			`FDR_OP_QUAD_ID: begin
				// address bit 0 swaps the order of the pair
				curByte = (byteSel_q[0] ^ addr_q[0]) ? DEV_ID : MFR_ID;
			end
			default: curByte = tableData;
		endcase
	end

	wire       curBit   = curByte[3'h7 - unitPos_q];
	wire [3:0] curNib   = unitPos_q[0] ? curByte[3:0] : curByte[7:4];
	wire       lastUnit = isQuad ? unitPos_q[0] : (unitPos_q == 3'h7);

	reg [7:0] byteSelNext;
	always @* begin
		case (opcode_q)
			`FDR_OP_JEDEC_ID:  byteSelNext = (byteSel_q == 8'h02) ? 8'h00 : byteSel_q + 8'h01;
			`FDR_OP_UNIQUE_ID: byteSelNext = {5'h00, byteSel_q[2:0] + 3'h1};
			default:           byteSelNext = byteSel_q + 8'h01;
		endcase
	end

	// ---------------------------------------------------------------
	// frame control on serial clock edges
	// ---------------------------------------------------------------
	always @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			state_q    <= ST_CMD;
			cnt_q      <= 7'h00;
			busyRead_q <= 1'b0;
		end else if (csS) begin
			// select high ends the frame from any state, cut frames too
			state_q    <= ST_CMD;
			cnt_q      <= 7'h00;
			busyRead_q <= 1'b0;
		end else begin
			state_q    <= state_d;
			busyRead_q <= (state_d == ST_DATA);
			// saturates so long data phases never wrap the count
			if (sclkRise && cnt_q != 7'h7f) begin
				cnt_q <= cnt_q + 7'h01;
			end
		end
	end

	// ---------------------------------------------------------------
	// opcode and address capture
	// ---------------------------------------------------------------
	always @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			opcode_q <= 8'h00;
			addr_q   <= 24'h000000;
		end else if (!csS && sclkRise) begin
			if (state_q == ST_CMD) begin
				opcode_q <= opcodeNext;
			end
			if (state_q == ST_ADDR) begin
				if (isQuad && cnt_q < `FDR_QUAD_ADDR_END) begin
					addr_q <= {addr_q[19:0], ioS};
				end else if (opcode_q == `FDR_OP_PARAM_TABLE &&
					cnt_q < `FDR_PARAM_ADDR_END) begin
					addr_q <= {addr_q[22:0], ioS[0]};
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// data output on serial clock falls
	// ---------------------------------------------------------------
	// first byte is chosen on the rise that closes the opcode, address or dummy clocks, whichever come last
	wire enterData = sclkRise & (state_d == ST_DATA) & (state_q != ST_DATA);

	always @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			byteSel_q <= 8'h00;
			unitPos_q <= 3'h0;
			ioOut_q   <= 4'h0;
			ioOe_q    <= OE_NONE;
		end else if (csS) begin
			// release the pins as soon as select is seen high
			unitPos_q <= 3'h0;
			ioOe_q    <= OE_NONE;
		end else if (enterData) begin
			unitPos_q <= 3'h0;
			if (opcode_q == `FDR_OP_PARAM_TABLE) begin
				byteSel_q <= addr_q[7:0];
			end else begin
				byteSel_q <= 8'h00;
			end
		end else if (sclkFall && state_q == ST_DATA) begin
			if (isQuad) begin
				ioOut_q <= curNib;
				ioOe_q  <= OE_QUAD;
			end else begin
				ioOut_q <= {2'b00, curBit, 1'b0};
				ioOe_q  <= OE_SINGLE;
			end
			if (lastUnit) begin
				unitPos_q <= 3'h0;
				byteSel_q <= byteSelNext;
			end else begin
				unitPos_q <= unitPos_q + 3'h1;
			end
		end
	end

	assign ioOut    = ioOut_q;
	assign ioOe     = ioOe_q;
	assign busyRead = busyRead_q;

endmodule // fdr_id_reads

`default_nettype wire

// *** include/fdr_map.vh ***
// constants for the identification and discovery read block
`ifndef FDR_MAP_VH
`define FDR_MAP_VH

// ---------------------------------------------------------------
// opcodes
// ---------------------------------------------------------------
`define FDR_OP_QUAD_ID      8'h94
`define FDR_OP_UNIQUE_ID    8'h4b
`define FDR_OP_JEDEC_ID     8'h9f
`define FDR_OP_PARAM_TABLE  8'h5a

// ---------------------------------------------------------------
// serial clock rising edge counts: end of opcode, end of address, first output edge
// ---------------------------------------------------------------
`define FDR_OPCODE_CLKS     7'h08
`define FDR_QUAD_ADDR_END   7'h0e
`define FDR_QUAD_ID_CLKS    7'h14
`define FDR_UNIQUE_ID_CLKS  7'h28
`define FDR_PARAM_ADDR_END  7'h20
`define FDR_PARAM_CLKS      7'h28

// ---------------------------------------------------------------
// parameter table contents
// ---------------------------------------------------------------
`define FDR_TBL_SIG0        8'h00
`define FDR_TBL_SIG1        8'h01
`define FDR_TBL_SIG2        8'h02
`define FDR_TBL_SIG3        8'h03
`define FDR_TBL_MINOR_REV   8'h04
`define FDR_TBL_MAJOR_REV   8'h05
`define FDR_TBL_HDR_COUNT   8'h06
`define FDR_TBL_RSVD7       8'h07
`define FDR_TBL_FIRST_ID    8'h08

`define FDR_SIG0_VAL        8'h53
`define FDR_SIG1_VAL        8'h46
`define FDR_SIG2_VAL        8'h44
`define FDR_SIG3_VAL        8'h50
`define FDR_MINOR_REV_VAL   8'h00
`define FDR_MAJOR_REV_VAL   8'h01
`define FDR_HDR_COUNT_VAL   8'h00
`define FDR_RSVD_VAL        8'hff
`define FDR_FIRST_ID_VAL    8'h00

`endif

// *** logic/fdr_pin_sync.v ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module fdr_pin_sync #(
	parameter          WIDTH     = 6,
	parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
	input  wire             clk,       // block clock
	input  wire             rstN,      // synchronised reset, active low
	input  wire [WIDTH-1:0] pinIn,     // raw pin levels
	output reg  [WIDTH-1:0] stable     // filtered levels
);

	reg [WIDTH-1:0] s1_q;
	reg [WIDTH-1:0] s2_q;
	reg [WIDTH-1:0] s3_q;

	always @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			s1_q <= RESET_VAL;
			s2_q <= RESET_VAL;
			s3_q <= RESET_VAL;
		end else begin
			s1_q <= pinIn;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// a change is taken only once the last two stages agree
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : gBit
			always @(posedge clk or negedge rstN) begin
				if (!rstN) begin
					stable[i] <= RESET_VAL[i];
				end else if (s2_q[i] == s3_q[i]) begin
					stable[i] <= s3_q[i];
				end
			end
		end
	endgenerate

endmodule // fdr_pin_sync

`default_nettype wire

// *** logic/fdr_param_table.v ***
// read-only discoverable-parameter table, 256 byte addresses
`timescale 1ns/1ps
`default_nettype none
`include "fdr_map.vh"

module fdr_param_table (
	input  wire [7:0] byteAddr,  // byte within the table
	output reg  [7:0] byteData   // table content at that byte
);

	always @* begin
		case (byteAddr)
			`FDR_TBL_SIG0:      byteData = `FDR_SIG0_VAL;
			`FDR_TBL_SIG1:      byteData = `FDR_SIG1_VAL;
			`FDR_TBL_SIG2:      byteData = `FDR_SIG2_VAL;
			`FDR_TBL_SIG3:      byteData = `FDR_SIG3_VAL;
			`FDR_TBL_MINOR_REV: byteData = `FDR_MINOR_REV_VAL;
			`FDR_TBL_MAJOR_REV: byteData = `FDR_MAJOR_REV_VAL;
			`FDR_TBL_HDR_COUNT: byteData = `FDR_HDR_COUNT_VAL;
			`FDR_TBL_FIRST_ID:  byteData = `FDR_FIRST_ID_VAL;
			// reserved and not-modelled bytes read as all ones
			default:            byteData = `FDR_RSVD_VAL;
		endcase
	end

endmodule // fdr_param_table

`default_nettype wire

// *** bench/fdr_id_reads_props.sv ***
// port checker for the identification read block
`timescale 1ns/1ps
`default_nettype none
module fdr_props (
	input wire logic       clk,        // block clock
	input wire logic       rst_n,      // reset, active low
	input wire logic       sclk,       // serial clock pin
	input wire logic       csN,        // select pin
	input wire logic [3:0] ioOut,      // drive values
	input wire logic [3:0] ioOe,       // drive enables
	input wire logic       powerDown,  // power-down state
	input wire logic       busyRead    // data phase flag
);
	// -----------------------------------------
	// helper and properties
	// -----------------------------------------
	logic pdHeld_q;
	// power-down already high at select fall covers the whole command
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			pdHeld_q <= 1'b0;
		else if (!powerDown)
			pdHeld_q <= 1'b0;
		else if ($fell(csN))
			pdHeld_q <= 1'b1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	oe_legal_a: assert property (ioOe == 4'h0 || ioOe == 4'h2 || ioOe == 4'hf)
		else $error("odd enable");
	single_line_a: assert property (ioOe == 4'h2 |-> ioOut[3:2] == 2'h0 && !ioOut[0])
		else $error("unused line driven");
	select_off_a: assert property (csN [*8] |-> ioOe == 4'h0)
		else $error("drive after select high");
	idle_quiet_a: assert property (!busyRead [*3] |-> ioOe == 4'h0)
		else $error("drive outside data phase");
	start_fall_a: assert property ($rose(|ioOe) |-> !$past(sclk, 4))
		else $error("drive not after falling edge");
	out_steady_a: assert property (sclk [*8] |=> $stable(ioOut))
		else $error("data moved while clock high");
	pd_ignore_a: assert property (pdHeld_q |-> ioOe == 4'h0)
		else $error("answer in power-down");
	opcode_quiet_a: assert property ($fell(csN) |-> (ioOe == 4'h0) [*8])
		else $error("drive during opcode");
	oe_stands_a: assert property (!csN [*6] ##0 (|ioOe) |=> $stable(ioOe))
		else $error("enable dropped in read");
endmodule // fdr_props
`default_nettype wire

// *** bench/fdr_host.sv ***
// spi host model that clocks the identification reads
`timescale 1ns/1ps
`default_nettype none
module fdr_host (
	output logic           sclk,   // serial clock, low when idle
	output logic           csN,    // select, active low
	output wire logic [3:0] ioIn,  // resolved pin levels
	input  wire logic [3:0] ioOut, // device drive values
	input  wire logic [3:0] ioOe   // device drive enables
);
	logic [3:0]  hOut;
	logic [63:0] got;
	logic        quad;
	// released lines flip each clock so a stale level never passes as data
	assign ioIn = (ioOe & ioOut) | (~ioOe & hOut);
	initial begin
		sclk = 1'b0;
		csN = 1'b1;
		hOut = 4'h0;
		quad = 1'b0;
	end
	task automatic tick(input logic drive, input logic [3:0] v);
		hOut = drive ? v : ~hOut;
		#40;
		sclk = 1'b1;
		got = quad ? {got[59:0], ioIn} : {got[62:0], ioIn[1]};
		#40;
		sclk = 1'b0;
	endtask
	// mode 1 table, 2 quad id, 3 unique id, else opcode only
	task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int mode, input int n);
		int i;
		quad = (mode == 2);
		#7;
		csN = 1'b0;
		#40;
		for (i = 7; i >= 0; i--) tick(1'b1, {3'h0, op[i]});
		if (mode == 1) for (i = 23; i >= 0; i--) tick(1'b1, {3'h0, a[i]});
		if (mode == 2) for (i = 5; i >= 0; i--) tick(1'b1, a[i*4 +: 4]);
		if (mode == 2) tick(1'b1, 4'hf);
		if (mode == 2) tick(1'b1, 4'h0);
		for (i = 0; i < (mode == 1 ? 8 : mode == 2 ? 4 : mode == 3 ? 32 : 0); i++) tick(1'b0, 4'h0);
		got = 64'h0;
		for (i = 0; i < n; i++) tick(1'b0, 4'h0);
		#40;
		csN = 1'b1;
		#200;
	endtask
endmodule // fdr_host
`default_nettype wire

// *** bench/fdr_id_reads_tb.sv ***
// self-checking bench for the identification read block
`timescale 1ns/1ps
`default_nettype none
module fdr_id_reads_tb;
	localparam logic [7:0]  MFR = 8'h3c; // arbitrary value
	localparam logic [7:0]  DEV = 8'h17; // arbitrary value
	localparam logic [7:0]  MTY = 8'h40;
	localparam logic [7:0]  CAP = 8'h18;
	localparam logic [63:0] UID = 64'h0123456789abcdef;
	logic       clk;
	logic       rst_n;
	logic       powerDown;
	wire        sclk;
	wire        csN;
	wire  [3:0] ioIn;
	wire  [3:0] ioOut;
	wire  [3:0] ioOe;
	wire        busyRead;
	int         badCount;
	int         nTests;
	int         driveCnt;
	int         cnt0;
	fdr_id_reads #(.MFR_ID(MFR), .DEV_ID(DEV), .MEM_TYPE(MTY), .CAPACITY(CAP), .UNIQUE_ID(UID))
	u_dut (.clk(clk), .rst_n(rst_n), .sclk(sclk), .csN(csN), .ioIn(ioIn), .ioOut(ioOut),
		.ioOe(ioOe), .powerDown(powerDown), .busyRead(busyRead));
	fdr_host u_host (.sclk(sclk), .csN(csN), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) if (|ioOe) driveCnt <= driveCnt + 1;
	task check(input logic [63:0] seen, input logic [63:0] exp);
		nTests++;
		if (seen !== exp) begin
			badCount++;
			$display("BAD %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", nTests, badCount);
		if (badCount == 0 && nTests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		#200000;
		badCount++;
		summarize;
	end
	initial begin
		rst_n = 1'b0;
		powerDown = 1'b0;
		badCount = 0;
		nTests = 0;
		driveCnt = 0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (12) @(posedge clk);
		u_host.cmd(8'h9f, 24'h0, 0, 48);
		check(u_host.got[47:0], {MFR, MTY, CAP, MFR, MTY, CAP});
		check(ioOe, 4'h0);
		check(busyRead, 1'b0);
		$display("identity read done");
		u_host.cmd(8'h94, 24'h0, 2, 8);
		check(u_host.got[31:0], {MFR, DEV, MFR, DEV});
		u_host.cmd(8'h94, 24'h1, 2, 8);
		check(u_host.got[31:0], {DEV, MFR, DEV, MFR});
		$display("quad id reads done");
		repeat (2) begin
			u_host.cmd(8'h4b, 24'h0, 3, 64);
			check(u_host.got, UID);
		end
		$display("unique id reads done");
		u_host.cmd(8'h5a, 24'h0, 1, 64);
		check(u_host.got, 64'h53464450000100ff);
		u_host.cmd(8'h5a, 24'h5, 1, 32);
		check(u_host.got[31:0], 32'h0100ff00);
		u_host.cmd(8'h5a, 24'hff, 1, 16);
		check(u_host.got[15:0], 16'hff53);
		$display("table reads done");
		powerDown <= 1'b1;
		@(posedge clk);
		cnt0 = driveCnt;
		u_host.cmd(8'h9f, 24'h0, 0, 24);
		check(64'(driveCnt), 64'(cnt0));
		$display("power-down read done");
		summarize;
	end
endmodule // fdr_id_reads_tb
bind fdr_id_reads fdr_props u_props (.clk(clk), .rst_n(rst_n), .sclk(sclk), .csN(csN),
	.ioOut(ioOut), .ioOe(ioOe), .powerDown(powerDown), .busyRead(busyRead));
`default_nettype wire
